// [logic/rrnc_pkg.sv]
// Purpose: constants for the plain rotate-right execution unit
// Assumes: 16-bit instruction words, 8-bit data, 12-bit data addresses
// Notes:   register offsets are word aligned byte addresses
package rrnc_pkg;
    localparam logic [3:0]  OP_TOP        = 4'h4;
    localparam logic [1:0]  OP_SUB        = 2'h0;
    localparam int          DEST_BIT      = 9;
    localparam int          BANKSEL_BIT   = 8;
    localparam int          ADDR_W        = 12;
    localparam int          BANK_W        = 4;
    localparam int          DEPTH         = 4096;
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0]  ACCESS_HIBANK = 4'hf;
    localparam logic [3:0]  ACCESS_LOBANK = 4'h0;
    // register map
    localparam logic [5:0]  REG_INSTR     = 6'h00;
    localparam logic [5:0]  REG_CTRL      = 6'h04;
    localparam logic [5:0]  REG_BANK      = 6'h08;
    localparam logic [5:0]  REG_ACC       = 6'h0c;
    localparam logic [5:0]  REG_STATUS    = 6'h10;
    localparam logic [5:0]  REG_MEMADDR   = 6'h14;
    localparam logic [5:0]  REG_MEMDATA   = 6'h18;
    localparam int          ST_CARRY      = 0;
    localparam int          ST_ZERO       = 2;
    localparam int          ST_NEG        = 4;
    localparam int          CTRL_GO       = 0;
    localparam int          STAT_BUSY     = 8;
    localparam int          STAT_ILLEGAL  = 9;
    localparam logic [31:0] BAD_ADDR_DATA = 32'h00000000;
    typedef enum logic [1:0] {RRNC_Q1, RRNC_Q2, RRNC_Q3, RRNC_Q4} rrnc_phase_t;
endpackage

// [logic/rrnc_file_mem.sv]
// Purpose: data memory holding the file registers
// Assumes: one read or one write per cycle
// Notes:   read data come out of a register
`timescale 1ns/100ps
module rrnc_file_mem
    import rrnc_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wrData,
    output logic      [7:0]        rdData_q
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData_q <= mem[addr];
    end
endmodule // rrnc_file_mem

// [logic/rrnc_exec.sv]
// Purpose: executes the plain rotate-right file instruction over four phases
// Assumes: classic Wishbone slave, ref_clk at 25 MHz, synchronous rst_n
// Notes:   software loads the instruction word and starts it with a go write
//
// What this block does
// - decode top nibble 0100 and next bits 00, then dest, bank, address
// - rotate operand one place right, bit 0 wraps to bit 7, no carry
// - dest bit 0 writes accumulator, dest bit 1 writes file register
// - bank bit 0 uses access bank, bank bit 1 uses bank select register
// - only negative and zero flags change from result; carry kept
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module rrnc_exec
    import rrnc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [15:0]       instr_q, instr_d;
    logic [BANK_W-1:0] bankSel_q, bankSel_d;
    logic [7:0]        acc_q, acc_d;
    logic [7:0]        status_q, status_d;
    logic [ADDR_W-1:0] memAddr_q, memAddr_d;
    logic              busy_q, busy_d;
    logic              illegal_q, illegal_d;
    rrnc_phase_t       phase_q, phase_d;
    logic              isRotate_q, isRotate_d;
    logic [ADDR_W-1:0] effAddr_q, effAddr_d;
    logic [7:0]        result_q, result_d;
    logic              ack_q, ack_d;
    logic [31:0]       rdData_q, rdData_d;
    logic              memWr;
    logic [ADDR_W-1:0] memAddrMux;
    logic [7:0]        memWrData;
    logic [7:0]        memRd;
    logic              busWr;
    logic              busRd;

    assign busWr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
    assign busRd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

    ////////////////////////////////////////////////////////////////////////////
    // memory port mux: the core owns the port while busy, so bus pokes
    // to data memory are dropped during an instruction
    always_comb begin
        memWr      = 1'b0;
        memAddrMux = memAddr_q;
        memWrData  = wb_dat_i[7:0];
        if (busy_q) begin
            memAddrMux = effAddr_q;
            memWrData  = result_q;
            memWr      = (phase_q == RRNC_Q4) && isRotate_q && instr_q[DEST_BIT];
        end else if (busWr && wb_adr_i == REG_MEMDATA && wb_sel_i[0]) begin
            memWr = 1'b1;
        end
    end

    rrnc_file_mem u_mem (
        .ref_clk (ref_clk),
        .wrEn    (memWr),
        .addr    (memAddrMux),
        .wrData  (memWrData),
        .rdData_q(memRd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // instruction sequencer
    always_comb begin
        phase_d    = phase_q;
        busy_d     = busy_q;
        isRotate_d = isRotate_q;
        effAddr_d  = effAddr_q;
        result_d   = result_q;
        acc_d      = acc_q;
        status_d   = status_q;
        illegal_d  = illegal_q;
        if (busy_q) begin
            unique case (phase_q)
                RRNC_Q1: begin
                    isRotate_d = instr_q[15:12] == OP_TOP
                              && instr_q[11:10] == OP_SUB;
                    illegal_d  = !isRotate_d;
                    if (!instr_q[BANKSEL_BIT]) begin
                        // lower half of access bank is bank 0, upper half the sfr bank
                        effAddr_d = {(instr_q[7:0] < ACCESS_SPLIT) ? ACCESS_LOBANK
                                     : ACCESS_HIBANK, instr_q[7:0]};
                    end else begin
                        effAddr_d = {bankSel_q, instr_q[7:0]};
                    end
                    phase_d = RRNC_Q2;
                end
                RRNC_Q2: begin
                    phase_d = RRNC_Q3;
                end
                RRNC_Q3: begin
                    result_d = {memRd[0], memRd[7:1]};
                    phase_d  = RRNC_Q4;
                end
                RRNC_Q4: begin
                    if (isRotate_q) begin
                        if (!instr_q[DEST_BIT]) begin
                            acc_d = result_q;
                        end
                        status_d[ST_NEG]  = result_q[7];
                        status_d[ST_ZERO] = result_q == 8'h00;
                    end
                    phase_d = RRNC_Q1;
                    busy_d  = 1'b0;
                end
            endcase
        end else if (busWr && wb_adr_i == REG_CTRL && wb_sel_i[0]
                     && wb_dat_i[CTRL_GO]) begin
            busy_d  = 1'b1;
            phase_d = RRNC_Q1;
        end else if (busWr && wb_adr_i == REG_ACC && wb_sel_i[0]) begin
            acc_d = wb_dat_i[7:0];
        end else if (busWr && wb_adr_i == REG_STATUS && wb_sel_i[0]) begin
            status_d = wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus registers and answer
    always_comb begin
        instr_d   = instr_q;
        bankSel_d = bankSel_q;
        memAddr_d = memAddr_q;
        ack_d     = wb_cyc_i && wb_stb_i && !ack_q;
        rdData_d  = BAD_ADDR_DATA;
        if (busWr && !busy_q) begin
            unique case (wb_adr_i)
                REG_INSTR: begin
                    if (wb_sel_i[0]) instr_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) instr_d[15:8] = wb_dat_i[15:8];
                end
                REG_BANK: begin
                    if (wb_sel_i[0]) bankSel_d = wb_dat_i[BANK_W-1:0];
                end
                REG_MEMADDR: begin
                    if (wb_sel_i[0]) memAddr_d[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) memAddr_d[ADDR_W-1:8] = wb_dat_i[ADDR_W-1:8];
                end
                default: ;
            endcase
        end
        if (busRd) begin
            unique case (wb_adr_i)
                REG_INSTR:   rdData_d = {16'h0000, instr_q};
                REG_BANK:    rdData_d = {28'h0000000, bankSel_q};
                REG_ACC:     rdData_d = {24'h000000, acc_q};
                REG_STATUS:  rdData_d = {22'h000000, illegal_q, busy_q, status_q};
                REG_MEMADDR: rdData_d = {20'h00000, memAddr_q};
                REG_MEMDATA: rdData_d = {24'h000000, memRd};
                default:     rdData_d = BAD_ADDR_DATA;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            instr_q    <= 16'h0000;
            bankSel_q  <= 4'h0;
            acc_q      <= 8'h00;
            status_q   <= 8'h00;
            memAddr_q  <= 12'h000;
            busy_q     <= 1'b0;
            illegal_q  <= 1'b0;
            phase_q    <= RRNC_Q1;
            isRotate_q <= 1'b0;
            effAddr_q  <= 12'h000;
            result_q   <= 8'h00;
            ack_q      <= 1'b0;
            rdData_q   <= 32'h00000000;
        end else begin
            instr_q    <= instr_d;
            bankSel_q  <= bankSel_d;
            acc_q      <= acc_d;
            status_q   <= status_d;
            memAddr_q  <= memAddr_d;
            busy_q     <= busy_d;
            illegal_q  <= illegal_d;
            phase_q    <= phase_d;
            isRotate_q <= isRotate_d;
            effAddr_q  <= effAddr_d;
            result_q   <= result_d;
            ack_q      <= ack_d;
            rdData_q   <= rdData_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdData_q;
endmodule // rrnc_exec

// [test/rrnc_exec_props.sv]
// Purpose: bus timing and read value checks
// Assumes: classic Wishbone, one clock
// Notes:   sees top ports only
`timescale 1ns/100ps
module rrnc_exec_props
    import rrnc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [5:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic rdAck = wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o;
    ////////////////////////////////////////////////////////////////
    property p_ackNext; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ackPulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_ackCause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    property p_ctrlZero; rdAck && wb_adr_i == REG_CTRL |-> wb_dat_o == 32'h0; endproperty
    property p_mapHole; rdAck && wb_adr_i > REG_MEMDATA |-> wb_dat_o == BAD_ADDR_DATA; endproperty
    property p_statBits; rdAck && wb_adr_i == REG_STATUS |-> (wb_dat_o & ~32'h315) == 32'h0;
    endproperty
    property p_accWidth; rdAck && wb_adr_i == REG_ACC |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_ackNext: assert property (p_ackNext) else $error("ack not one cycle after take");
    a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    a_ctrlZero: assert property (p_ctrlZero) else $error("go register reads nonzero");
    a_mapHole: assert property (p_mapHole) else $error("unmapped read nonzero");
    a_statBits: assert property (p_statBits) else $error("status spare bit set");
    a_accWidth: assert property (p_accWidth) else $error("accumulator upper bits set");
    c_busy: cover property (rdAck && wb_adr_i == REG_STATUS && wb_dat_o[STAT_BUSY]);
    c_bad: cover property (rdAck && wb_adr_i == REG_STATUS && wb_dat_o[STAT_ILLEGAL]);
    c_zero: cover property (rdAck && wb_adr_i == REG_STATUS && wb_dat_o[ST_ZERO]);
endmodule // rrnc_exec_props
bind rrnc_exec rrnc_exec_props uProps (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// [test/rrnc_exec_tb.sv]
// Purpose: runs the rotate unit through its bus
// Assumes: one request at a time, sel all ones
// Notes:   illegal words last, they leave the freshly written flags alone
`timescale 1ns/100ps
module rrnc_exec_tb;
    import rrnc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        wbCyc   = 1'b0;
    logic        wbStb   = 1'b0;
    logic        wbWe    = 1'b0;
    logic [5:0]  wbAdr   = 6'h00;
    logic [31:0] wbDatI  = 32'h0;
    logic [31:0] wbDatO;
    logic        wbAck;
    logic        expN    = 1'b0;
    logic        expZ    = 1'b0;
    logic [31:0] r;
    int          fail_count  = 0;
    int          checks_done = 0;
    always #20 ref_clk = ~ref_clk;
    rrnc_exec DUT (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI),
        .wb_dat_o(wbDatO), .wb_ack_o(wbAck));
    ////////////////////////////////////////////////////////////////
    task test_done;
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // holds the request until ack is sampled, then one idle cycle
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= w;
        wbAdr  <= a;
        wbDatI <= d;
        do @(posedge ref_clk); while (wbAck !== 1'b1);
        r = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge ref_clk);
    endtask
    // pa is the physical address the word should resolve to
    task run(input logic [15:0] ins, input logic [3:0] bk, input logic [11:0] pa,
             input logic [7:0] v, input logic cy);
        logic [7:0] res;
        logic       ok;
        int         n;
        res = {v[0], v[7:1]};
        ok = (ins[15:10] === 6'h10);
        wb(1'b1, REG_BANK, {28'h0, bk});
        wb(1'b1, REG_MEMADDR, {20'h0, pa});
        wb(1'b1, REG_MEMDATA, {24'h0, v});
        wb(1'b1, REG_ACC, 32'h5a);
        wb(1'b1, REG_STATUS, {31'h0, cy});
        wb(1'b1, REG_INSTR, {16'h0, ins});
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b0, REG_STATUS, 32'h0);
        chk("busy", 32'h1, {31'h0, r[STAT_BUSY]});
        // the status write above cleared negative and zero
        expN = 1'b0;
        expZ = 1'b0;
        n = 0;
        while (r[STAT_BUSY] !== 1'b0 && n < 4) begin
            wb(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        if (ok) begin
            expN = res[7];
            expZ = (res == 8'h00);
        end
        chk("status", {22'h0, ~ok, 4'h0, expN, 1'b0, expZ, 1'b0, cy}, r);
        wb(1'b0, REG_ACC, 32'h0);
        chk("acc", {24'h0, (ok && !ins[DEST_BIT]) ? res : 8'h5a}, r);
        wb(1'b0, REG_MEMDATA, 32'h0);
        chk("file", {24'h0, (ok && ins[DEST_BIT]) ? res : v}, r);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        run(16'h4210, 4'h3, 12'h010, 8'hd7, 1'b1);
        run(16'h4122, 4'h3, 12'h322, 8'h01, 1'b0);
        run(16'h4285, 4'h5, 12'hf85, 8'h00, 1'b1);
        run(16'h427f, 4'h2, 12'h07f, 8'h80, 1'b1);
        run(16'h4390, 4'hf, 12'hf90, 8'h02, 1'b0);
        run(16'h4090, 4'h5, 12'hf90, 8'hfe, 1'b0);
        run(16'h4610, 4'h0, 12'h010, 8'h55, 1'b1);
        run(16'h3210, 4'h0, 12'h010, 8'h33, 1'b0);
        wb(1'b0, 6'h3c, 32'h0);
        chk("hole", BAD_ADDR_DATA, r);
        test_done;
    end
    initial begin
        #100000;
        fail_count++;
        test_done;
    end
endmodule // rrnc_exec_tb
